// >>> vrc_defs.vh
// Purpose: constants for the voltage reference control block
// Assumes: word-aligned APB registers, 8-bit registers in the low byte
// Notes: offsets are byte addresses
`ifndef VRC_DEFS_VH
`define VRC_DEFS_VH
`define VRC_ADDR_LADDER 12'h000
`define VRC_ADDR_FIXED 12'h004
`define VRC_ADDR_STATUS 12'h008
`define VRC_LAD_EN 7
`define VRC_LAD_PIN 6
`define VRC_LAD_RANGE 5
`define VRC_LAD_SRC 4
`define VRC_FIX_EN 7
`define VRC_FIX_STABLE 6
`define VRC_LADDER_RST 8'h00
`define VRC_FIXED_WMASK 8'h80
// settling time of the fixed reference, in ns
`define VRC_SETTLE_NS 10000
`define VRC_CLK_MHZ 250
`define VRC_SETTLE_CYC ((`VRC_SETTLE_NS * `VRC_CLK_MHZ + 999) / 1000)
`endif

// >>> vrc_sync3.v
// Purpose: three-flop synchroniser with agreement filter
// Assumes: input asynchronous to core_clk
// Notes: output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module vrc_sync3 (
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // signal
   input wire asyncIn,
   output reg syncOut
);
   reg s1;
   reg s2;
   reg s3;

   // first stage feeds only the second
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         s1 <= asyncIn;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            syncOut <= s3;
         end
      end
   end
endmodule
`default_nettype wire

// >>> vrc_ctrl.v
// Purpose: register and control logic for ladder and fixed references
// Assumes: APB slave, 250 MHz core_clk, analog parts outside
// Notes: outputs all come from flip-flops
`timescale 1ns/10ps
`default_nettype none
`include "vrc_defs.vh"
module vrc_ctrl #(
   parameter SETTLE_CYC = `VRC_SETTLE_CYC
) (
   // clock and reset
   input wire core_clk,
   input wire rstn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // requests from other blocks, asynchronous
   input wire fastOscOn,
   input wire voltDetectOn,
   input wire brownoutOn,
   // pin side
   input wire portDirection,
   input wire pinDigitalIn,
   output reg pinOutBufEn,
   output reg pinInDetEn,
   output reg pinReadValue,
   // analog ladder controls
   output reg ladderPower,
   output reg ladderPinConnect,
   output reg ladderLowRange,
   output reg ladderExtSource,
   output reg ladderClamp,
   output reg [3:0] ladderLevel,
   output reg [5:0] ladderTapNum,
   output reg [5:0] ladderTapDen,
   // fixed reference
   output reg fixedPower,
   output reg fixedStable
);
   reg [7:0] ladderCtl;
   reg fixedEnable;
   reg [31:0] settleCnt;
   reg lastPower;
   wire oscSync;
   wire vdSync;
   wire borSync;
   wire pinSync;
   wire fixedOn;
   wire apbWrite;
   wire apbRead;

   // outside requests cross into core_clk
   vrc_sync3 uOsc (.core_clk(core_clk), .rstn(rstn),
      .asyncIn(fastOscOn), .syncOut(oscSync));
   vrc_sync3 uVd (.core_clk(core_clk), .rstn(rstn),
      .asyncIn(voltDetectOn), .syncOut(vdSync));
   vrc_sync3 uBor (.core_clk(core_clk), .rstn(rstn),
      .asyncIn(brownoutOn), .syncOut(borSync));
   vrc_sync3 uPin (.core_clk(core_clk), .rstn(rstn),
      .asyncIn(pinDigitalIn), .syncOut(pinSync));

   // zero-wait apb: access phase completes in its first cycle
   assign apbWrite = psel && penable && pwrite;
   assign apbRead = psel && penable && !pwrite;
   assign fixedOn = fixedEnable | oscSync | vdSync | borSync;

   // register writes; no sleep input exists, so wake keeps contents
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ladderCtl <= `VRC_LADDER_RST;
         fixedEnable <= 1'b0;
      end else if (apbWrite) begin
         if (paddr == `VRC_ADDR_LADDER) begin
            ladderCtl <= pwdata[7:0];
         end else if (paddr == `VRC_ADDR_FIXED) begin
            // only bit 7 is writable
            fixedEnable <= pwdata[`VRC_FIX_EN];
         end
      end
   end

   // apb answer; unmapped addresses read zero and flag an error
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (psel && !penable) begin
            case (paddr)
               `VRC_ADDR_LADDER: prdata <= {24'h000000, ladderCtl};
               `VRC_ADDR_FIXED: prdata <= {24'h000000, fixedEnable,
                  fixedStable, 6'h00};
               `VRC_ADDR_STATUS: prdata <= {28'h0000000, borSync, vdSync,
                  oscSync, fixedPower};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // settle counter restarts whenever the fixed reference powers up
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         settleCnt <= 32'h00000000;
         lastPower <= 1'b0;
         fixedPower <= 1'b0;
         fixedStable <= 1'b0;
      end else begin
         fixedPower <= fixedOn;
         lastPower <= fixedOn;
         if (!fixedOn || !lastPower) begin
            settleCnt <= 32'h00000000;
            fixedStable <= 1'b0;
         end else if (settleCnt >= SETTLE_CYC - 1) begin
            fixedStable <= 1'b1;
         end else begin
            settleCnt <= settleCnt + 32'h00000001;
         end
      end
   end

   // ladder outputs depend only on ladderCtl; pin outputs also use portDirection and pinSync
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ladderPower <= 1'b0;
         ladderPinConnect <= 1'b0;
         ladderLowRange <= 1'b0;
         ladderExtSource <= 1'b0;
         ladderClamp <= 1'b0;
         ladderLevel <= 4'h0;
         ladderTapNum <= 6'h08;
         ladderTapDen <= 6'h20;
         pinOutBufEn <= 1'b0;
         pinInDetEn <= 1'b1;
         pinReadValue <= 1'b0;
      end else begin
         ladderPower <= ladderCtl[`VRC_LAD_EN];
         ladderPinConnect <= ladderCtl[`VRC_LAD_PIN];
         ladderLowRange <= ladderCtl[`VRC_LAD_RANGE];
         ladderExtSource <= ladderCtl[`VRC_LAD_SRC];
         ladderLevel <= ladderCtl[3:0];
         // tap fraction of span: code/24 or (8+code)/32
         if (ladderCtl[`VRC_LAD_RANGE]) begin
            ladderTapNum <= {2'b00, ladderCtl[3:0]};
            ladderTapDen <= 6'h18;
         end else begin
            ladderTapNum <= 6'h08 + {2'b00, ladderCtl[3:0]};
            ladderTapDen <= 6'h20;
         end
         ladderClamp <= !ladderCtl[`VRC_LAD_EN] &&
            ladderCtl[`VRC_LAD_RANGE] && (ladderCtl[3:0] == 4'h0);
         // reference mode overrides the port direction bit
         pinOutBufEn <= !ladderCtl[`VRC_LAD_PIN] && !portDirection;
         pinInDetEn <= !ladderCtl[`VRC_LAD_PIN];
         pinReadValue <= ladderCtl[`VRC_LAD_PIN] ? 1'b0 : pinSync;
      end
   end

   // read-side unused bits of write data are simply ignored
   wire unusedApb;
   assign unusedApb = apbRead;
endmodule
`default_nettype wire

// >>> vrc_ref_model.sv
// Purpose: behavioural ladder and reference pin on the far side
// Assumes: span in millivolts, level taken from the tap fraction
// Notes: a pin that carries the analog level has no logic value
`timescale 1ns/10ps
`default_nettype none
module vrc_ref_model #(parameter int SPAN_MV = 3300) (
   // ladder controls
   input wire logic core_clk,
   input wire logic ladderPower,
   input wire logic ladderPinConnect,
   input wire logic ladderClamp,
   input wire logic [5:0] ladderTapNum,
   input wire logic [5:0] ladderTapDen,
   // pin and level
   output logic pinDigitalIn,
   output int refMv
);
   // no divider current gives no level; clamp ties the output to ground
   always_comb refMv = (ladderPower && !ladderClamp) ?
      SPAN_MV * ladderTapNum / ladderTapDen : 0;
   // an analog pin reads as noise, so toggle to expose any leak
   initial pinDigitalIn = 1'b1;
   always @(posedge core_clk) pinDigitalIn <= !pinDigitalIn;
endmodule
`default_nettype wire

// >>> vrc_ctrl_checker.sv
// Purpose: port assertions for the reference control block
// Assumes: all ports sampled on core_clk
// Notes: bound to every vrc_ctrl instance
`timescale 1ns/10ps
`default_nettype none
module vrc_ctrl_checker (
   // clock, reset and bus
   input wire logic core_clk, rstn, psel, penable, pwrite, pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // requests and pin
   input wire logic fastOscOn, voltDetectOn, brownoutOn,
   input wire logic pinOutBufEn, pinInDetEn, pinReadValue,
   // references
   input wire logic ladderPower, ladderPinConnect, ladderLowRange,
   input wire logic ladderClamp, fixedPower,
   input wire logic [3:0] ladderLevel,
   input wire logic [5:0] ladderTapNum, ladderTapDen
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   chk_apb_ready: assert property (psel && !penable |=> pready)
      else $error("ready missing after setup");
   chk_ladder_write: assert property (psel && penable && pwrite && pready
      && paddr == 12'h000 |=> ##1 ladderPower == $past(pwdata[7], 2)
      && ladderLevel == $past(pwdata[3:0], 2))
      else $error("ladder write not applied");
   chk_tap_low: assert property (ladderLowRange |->
      ladderTapNum == {2'h0, ladderLevel} && ladderTapDen == 6'h18)
      else $error("low range tap wrong");
   chk_tap_high: assert property (!ladderLowRange |->
      ladderTapNum == ladderLevel + 6'h8 && ladderTapDen == 6'h20)
      else $error("high range tap wrong");
   chk_clamp_cond: assert property (ladderClamp == (!ladderPower
      && ladderLowRange && ladderLevel == 4'h0))
      else $error("clamp condition wrong");
   chk_pin_bufs: assert property (ladderPinConnect |->
      !pinOutBufEn && !pinInDetEn) else $error("pin buffers left on");
   chk_pin_read: assert property (ladderPinConnect |-> !pinReadValue)
      else $error("reference pin read not zero");
   chk_fixed_force: assert property ((fastOscOn || voltDetectOn
      || brownoutOn) [*8] |-> fixedPower) else $error("fixed ref not forced");
endmodule
bind vrc_ctrl vrc_ctrl_checker u_chk (.*);
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench for the reference control block
// Assumes: zero-wait APB slave, short settling count
// Notes: rows cover ladder settings, hand tests the rest
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, portDirection = 1'b0, fastOscOn = 1'b0;
   logic voltDetectOn = 1'b0, brownoutOn = 1'b0, pready, pslverr, err;
   logic pinDigitalIn, pinOutBufEn, pinInDetEn, pinReadValue, fixedStable;
   logic ladderPower, ladderPinConnect, ladderLowRange, ladderExtSource;
   logic ladderClamp, fixedPower;
   logic [3:0] ladderLevel;
   logic [5:0] ladderTapNum, ladderTapDen;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int n_mismatch = 0, n_checks = 0, cyc = 0, refMv;
   // written byte, tap numerator, denominator, clamp
   logic [31:0] rows [6] = '{32'h80082000, 32'h2F0F1800, 32'h20001801,
      32'h75051800, 32'h10082000, 32'hDF172000};
   always #2 core_clk = ~core_clk;
   vrc_ctrl #(.SETTLE_CYC(8)) u_dut (.*);
   vrc_ref_model u_model (.*);
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one transfer; waits for ready, only the bench timeout ends a hang
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) begin
         @(posedge core_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b1, 12'h000, rows[i][31:24]);
         @(posedge core_clk);
         #1;
         chk({24'h0, ladderPower, ladderPinConnect, ladderLowRange,
            ladderExtSource, ladderLevel}, {24'h0, rows[i][31:24]});
         chk({10'h0, ladderTapNum, 2'h0, ladderTapDen, 7'h0, ladderClamp},
            {8'h0, rows[i][23:0]});
         chk({30'h0, pinOutBufEn, pinInDetEn},
            {30'h0, !rows[i][30], !rows[i][30]});
         if (rows[i][30]) chk({31'h0, pinReadValue}, 32'h0);
         chk(refMv, (rows[i][31] && !rows[i][0]) ? 3300 *
            int'(rows[i][21:16]) / int'(rows[i][13:8]) : 0);
         apb(1'b0, 12'h000, 8'h00);
         chk(rd, {24'h0, rows[i][31:24]});
      end
      // reset in mid-run with the ladder still set from the last row
      rstn <= 1'b0;
      @(posedge core_clk);
      #1;
      chk({16'h0, ladderPower, ladderPinConnect, ladderLowRange, fixedPower,
         ladderLevel, 2'h0, ladderTapNum}, 32'h8);
      @(posedge core_clk);
      rstn <= 1'b1;
      apb(1'b1, 12'h004, 8'hFF);
      apb(1'b0, 12'h004, 8'h00);
      chk(rd, 32'h80);
      repeat (20) @(posedge core_clk);
      apb(1'b0, 12'h004, 8'h00);
      chk(rd, 32'hC0);
      apb(1'b1, 12'h004, 8'h00);
      // each request alone must hold the fixed reference on
      for (int k = 0; k < 4; k++) begin
         {fastOscOn, voltDetectOn, brownoutOn} <= 3'h1 << k;
         repeat (12) @(posedge core_clk);
         chk({31'h0, fixedPower}, {31'h0, k < 3});
      end
      apb(1'b0, 12'h004, 8'h00);
      chk(rd, 32'h0);
      apb(1'b0, 12'h00C, 8'h00);
      chk({rd[30:0], err}, 32'h1);
      conclude();
   end
endmodule
`default_nettype wire
